/* rtl/bioprt_pkg.sv */
// Package for the bidirectional port block: widths, reset values, operation codes
`default_nettype none
package bioprt_pkg;
  localparam int BIOPRT_WIDTH = 8;
  localparam logic [7:0] BIOPRT_LATCH_RST = 8'h00;
  localparam logic [7:0] BIOPRT_DIR_RST = 8'hFF;
  localparam int BIOPRT_SYNC_STAGES = 2;
  // Operation presented by the core for one instruction cycle
  typedef enum logic [2:0] {
    BIOPRT_OP_NONE = 3'h0,
    BIOPRT_OP_READ = 3'h1,
    BIOPRT_OP_WRITE = 3'h2,
    BIOPRT_OP_BSET = 3'h3,
    BIOPRT_OP_BCLR = 3'h4,
    BIOPRT_OP_DIRW = 3'h5
  } bioprt_op_t;
endpackage
`default_nettype wire

/* rtl/bioprt_sync.sv */
// Two-flop synchroniser for the pin inputs
`default_nettype none
module bioprt_sync
  import bioprt_pkg::*;
#(
  parameter int WIDTH = BIOPRT_WIDTH
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] sync_r;
  logic [WIDTH-1:0] sync_nxt;

  // Next values: first stage feeds only the second
  always_comb
  begin
    meta_nxt = async_in;
    sync_nxt = meta_r;
  end

  // Register both stages
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      meta_r <= '0;
      sync_r <= '0;
    end
    else
    begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign sync_out = sync_r;
endmodule
`default_nettype wire

/* rtl/bioprt_port.sv */
// Bidirectional I/O port with read-modify-write behaviour
// Overview of operation
// R1 - A port data read returns the sampled pin levels, never the latch contents.
// R2 - A port data write stores the value in the output latch until the next write.
// R3 - Every writing operation reads the whole port, modifies it, and writes it all back; here only bit set/clear do this, a plain write stores wr_data.
// R4 - In a read-modify-write, input pins have their latch overwritten by the pin level.
// R5 - A pin turned from input to output drives whatever its latch holds then.
// R6 - A latch write takes effect at the end of the writing instruction cycle.
// R7 - A read samples the pin levels at the start of the reading cycle.
// R8 - Software should leave one unrelated cycle between a write and a read of the port; here the two synchroniser flops need two such cycles.
// R9 - A direction bit of one makes the pin an input; zero makes it drive the latch.
`default_nettype none
module bioprt_port
  import bioprt_pkg::*;
#(
  parameter int WIDTH = BIOPRT_WIDTH
)
(
  input wire logic clk,
  input wire logic reset,
  input wire bioprt_op_t op,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [2:0] bit_sel,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_out,
  output logic [WIDTH-1:0] pin_oe,
  output logic [WIDTH-1:0] rd_data,
  output logic [WIDTH-1:0] latch_out,
  output logic [WIDTH-1:0] dir_out
);
  // Synchronised pins, state registers and their next values
  logic [WIDTH-1:0] pin_sync;
  logic [WIDTH-1:0] latch_r;
  logic [WIDTH-1:0] latch_nxt;
  logic [WIDTH-1:0] dir_r;
  logic [WIDTH-1:0] dir_nxt;
  logic [WIDTH-1:0] rd_r;
  logic [WIDTH-1:0] rd_nxt;
  logic [WIDTH-1:0] oe_r;
  logic [WIDTH-1:0] oe_nxt;
  logic [WIDTH-1:0] out_r;
  logic [WIDTH-1:0] out_nxt;

  // Pin levels pass two flops before use
  bioprt_sync #(.WIDTH(WIDTH)) bioprt_sync_i
  (
    .clk(clk),
    .reset(reset),
    .async_in(pin_in),
    .sync_out(pin_sync)
  );

  // One-hot mask for the selected bit
  function automatic logic [WIDTH-1:0] bit_mask(input logic [2:0] sel);
    logic [WIDTH-1:0] m;
    m = '0;
    m[sel] = 1'b1;
    return m;
  endfunction

  // Next values of latch, direction, read data and pin drivers
  always_comb
  begin
    latch_nxt = latch_r;
    dir_nxt = dir_r;
    rd_nxt = rd_r;
    case (op)
      BIOPRT_OP_READ:
      begin
        rd_nxt = pin_sync; // [R1] [R7]
      end
      BIOPRT_OP_WRITE:
      begin
        latch_nxt = wr_data; // [R2] [R6]
      end
      BIOPRT_OP_BSET:
      begin
        latch_nxt = pin_sync | bit_mask(bit_sel); // [R3] [R4]
      end
      BIOPRT_OP_BCLR:
      begin
        latch_nxt = pin_sync & ~bit_mask(bit_sel); // [R3] [R4]
      end
      BIOPRT_OP_DIRW:
      begin
        dir_nxt = wr_data;
      end
      default:
      begin
        latch_nxt = latch_r;
      end
    endcase
    oe_nxt = ~dir_nxt; // [R9]
    out_nxt = latch_nxt; // [R5]
  end

  // Register state; outputs come straight from flops
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      latch_r <= BIOPRT_LATCH_RST;
      dir_r <= BIOPRT_DIR_RST;
      rd_r <= '0;
      oe_r <= ~BIOPRT_DIR_RST;
      out_r <= BIOPRT_LATCH_RST;
    end
    else
    begin
      latch_r <= latch_nxt;
      dir_r <= dir_nxt;
      rd_r <= rd_nxt;
      oe_r <= oe_nxt;
      out_r <= out_nxt;
    end
  end

  // Drive the ports from the registers
  assign pin_out = out_r;
  assign pin_oe = oe_r;
  assign rd_data = rd_r;
  assign latch_out = latch_r;
  assign dir_out = dir_r;

  // Checks on the port behaviour, grouped by the rule that each one guards

  // Read path
  // Read data is the synchronised pin level seen at the start of the cycle
  a_read_pins: assert property (@(posedge clk) disable iff (reset) // [R1] [R7]
    op == BIOPRT_OP_READ |=> rd_data == $past(pin_sync))
    else $error("Read data is not the sampled pin level");
  // Read data holds between reads, so a later write cannot leak into it
  a_read_hold: assert property (@(posedge clk) disable iff (reset) // [R1]
    op != BIOPRT_OP_READ |=> $stable(rd_data))
    else $error("Read data changed without a read");
  // A read leaves latch and direction untouched
  a_read_keep: assert property (@(posedge clk) disable iff (reset) // [R1]
    op == BIOPRT_OP_READ |=> $stable(latch_out) && $stable(dir_out))
    else $error("Read disturbed latch or direction");

  // Latch path
  // Plain write lands in the latch at the end of the writing cycle
  a_write_latch: assert property (@(posedge clk) disable iff (reset) // [R2]
    op == BIOPRT_OP_WRITE |=> latch_out == $past(wr_data))
    else $error("Write did not store into the latch");
  // Latch only moves on a writing operation
  a_latch_hold: assert property (@(posedge clk) disable iff (reset) // [R2]
    op inside {BIOPRT_OP_NONE, BIOPRT_OP_READ, BIOPRT_OP_DIRW} |=> $stable(latch_out))
    else $error("Latch changed without a write");
  // Idle cycles leave latch, direction and read data alone
  a_idle_quiet: assert property (@(posedge clk) disable iff (reset) // [R2]
    op == BIOPRT_OP_NONE |=> $stable(latch_out) && $stable(dir_out) && $stable(rd_data))
    else $error("State changed in an idle cycle");
  // Bit set: whole port read, one bit set, all bits written back
  a_bset_rmw: assert property (@(posedge clk) disable iff (reset) // [R3]
    op == BIOPRT_OP_BSET |=> latch_out == ($past(pin_sync) | bit_mask($past(bit_sel))))
    else $error("Bit set did not write pin levels with the bit set");
  // Bit set always leaves the selected bit high
  a_bset_sel: assert property (@(posedge clk) disable iff (reset) // [R3]
    op == BIOPRT_OP_BSET |=> latch_out[$past(bit_sel)] == 1'b1)
    else $error("Bit set left the selected bit low");
  // Bit clear: same path with the selected bit cleared
  a_bclr_rmw: assert property (@(posedge clk) disable iff (reset) // [R4]
    op == BIOPRT_OP_BCLR |=> latch_out == ($past(pin_sync) & ~bit_mask($past(bit_sel))))
    else $error("Bit clear did not write pin levels with the bit cleared");
  // Bit clear always leaves the selected bit low
  a_bclr_sel: assert property (@(posedge clk) disable iff (reset) // [R3]
    op == BIOPRT_OP_BCLR |=> latch_out[$past(bit_sel)] == 1'b0)
    else $error("Bit clear left the selected bit high");
  // Input pins other than the selected bit take their sensed level
  a_rmw_inputs: assert property (@(posedge clk) disable iff (reset) // [R4]
    op inside {BIOPRT_OP_BSET, BIOPRT_OP_BCLR} |=>
    ((latch_out ^ $past(pin_sync)) & $past(dir_out) & ~bit_mask($past(bit_sel))) == '0)
    else $error("Input pin latch not overwritten by its pin level");

  // Pin drivers
  // Pin driver always mirrors the latch
  a_drive_latch: assert property (@(posedge clk) disable iff (reset) // [R5]
    pin_out == latch_out)
    else $error("Pin driver differs from latch");
  // A pin turned to output drives what the latch held at the switch
  a_turn_output: assert property (@(posedge clk) disable iff (reset) // [R5]
    op == BIOPRT_OP_DIRW |=> pin_out == $past(latch_out))
    else $error("Pin turned to output does not drive the held latch");
  // Write reaches the pins by the following cycle
  a_write_timing: assert property (@(posedge clk) disable iff (reset) // [R6]
    op == BIOPRT_OP_WRITE ##1 op == BIOPRT_OP_NONE |-> pin_out == $past(wr_data))
    else $error("Write not on pins at end of cycle");
  // Nothing moves the latch before the edge that ends the writing cycle
  a_write_not_early: assert property (@(posedge clk) disable iff (reset) // [R6]
    op == BIOPRT_OP_WRITE && $past(op) == BIOPRT_OP_NONE |-> $stable(latch_out))
    else $error("Latch changed before the end of the writing cycle");

  // Direction and enable
  // Enable is the inverse of direction
  a_dir_enable: assert property (@(posedge clk) disable iff (reset) // [R9]
    pin_oe == ~dir_out)
    else $error("Output enable does not follow direction");
  // Direction write lands in the direction register
  a_dir_write: assert property (@(posedge clk) disable iff (reset) // [R9]
    op == BIOPRT_OP_DIRW |=> dir_out == $past(wr_data))
    else $error("Direction write did not store");
  // Enable after a direction write is the inverse of the written word
  a_dir_oe: assert property (@(posedge clk) disable iff (reset) // [R9]
    op == BIOPRT_OP_DIRW |=> pin_oe == ~$past(wr_data))
    else $error("Enable does not match the written direction");
  // Direction holds between direction writes
  a_dir_hold: assert property (@(posedge clk) disable iff (reset) // [R9]
    op != BIOPRT_OP_DIRW |=> $stable(dir_out))
    else $error("Direction changed without a direction write");
  // Reset leaves every pin an input with a cleared latch
  a_reset_state: assert property (@(posedge clk) // [R9]
    reset |=> latch_out == BIOPRT_LATCH_RST && dir_out == BIOPRT_DIR_RST && pin_oe == '0)
    else $error("Port not in its reset state after reset");

  // Scenarios worth seeing
  c_rmw_then_out: cover property (@(posedge clk) disable iff (reset)
    op == BIOPRT_OP_BCLR ##1 op == BIOPRT_OP_DIRW);
  c_write_read: cover property (@(posedge clk) disable iff (reset)
    op == BIOPRT_OP_WRITE ##2 op == BIOPRT_OP_READ);
  c_bset: cover property (@(posedge clk) disable iff (reset) op == BIOPRT_OP_BSET);
  c_input_captured: cover property (@(posedge clk) disable iff (reset)
    op == BIOPRT_OP_BCLR ##[1:8] op == BIOPRT_OP_READ);
  c_turn_output: cover property (@(posedge clk) disable iff (reset)
    op == BIOPRT_OP_BSET ##[1:8] op == BIOPRT_OP_DIRW);
endmodule
`default_nettype wire

/* tb/bioprt_ext.sv */
// External circuit model on the port pins
`default_nettype none
module bioprt_ext
(
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] ext_val,
  output logic [7:0] pin_level
);
  timeunit 1ns;
  timeprecision 1ps;
  // Driven bits follow the port, released bits follow the outside source
  assign pin_level = (pin_oe & pin_out) | (~pin_oe & ext_val);
endmodule
`default_nettype wire

/* tb/bioprt_port_tb.sv */
// Self-checking bench for the bidirectional port
`default_nettype none
module bioprt_port_tb
  import bioprt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic reset = 1'b1;
  bioprt_op_t op = BIOPRT_OP_NONE;
  logic [7:0] wr_data = 8'h00;
  logic [2:0] bit_sel = 3'h0;
  logic [7:0] ext_val = 8'hC0;
  logic [7:0] pin_in, pin_out, pin_oe, rd_data, latch_out, dir_out;
  int fail_count = 0;
  int samples_checked = 0;
  bioprt_port bioprt_port_i (.clk(clk), .reset(reset), .op(op), .wr_data(wr_data),
    .bit_sel(bit_sel), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .rd_data(rd_data), .latch_out(latch_out), .dir_out(dir_out));
  bioprt_ext bioprt_ext_i (.pin_out(pin_out), .pin_oe(pin_oe), .ext_val(ext_val),
    .pin_level(pin_in));
  // Clock of 4 ns period
  initial
  begin
    forever #2 clk = ~clk;
  end
  // Compares one byte
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Spacer cycles let the pins settle, then one operation
  task automatic step(input bioprt_op_t o, input logic [7:0] d, input logic [2:0] b);
    repeat (3) @(posedge clk);
    op <= o;
    wr_data <= d;
    bit_sel <= b;
    @(posedge clk);
    op <= BIOPRT_OP_NONE;
    #1;
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Values right after reset
  task automatic scn_reset;
    check(latch_out, 8'h00);
    check(dir_out, 8'hFF);
    check(pin_oe, 8'h00);
    check(pin_out, 8'h00);
    check(rd_data, 8'h00);
  endtask
  // Write lands in the latch, read returns pins
  task automatic scn_write_read;
    step(BIOPRT_OP_WRITE, 8'hA5, 3'h0);
    check(latch_out, 8'hA5);
    @(posedge clk);
    ext_val <= 8'h3C;
    step(BIOPRT_OP_READ, 8'h00, 3'h0);
    check(rd_data, 8'h3C);
    check(latch_out, 8'hA5);
  endtask
  // Bit operations copy input pins into the latch
  task automatic scn_rmw;
    step(BIOPRT_OP_BSET, 8'hFF, 3'h0);
    check(latch_out, 8'h3D);
    // Upper nibble stays input, lower nibble turns output
    step(BIOPRT_OP_DIRW, 8'hF0, 3'h0);
    check(dir_out, 8'hF0);
    check(pin_oe, 8'h0F);
    check(pin_out, 8'h3D);
    check(pin_in, 8'h3D);
    @(posedge clk);
    ext_val <= 8'hC0;
    step(BIOPRT_OP_BCLR, 8'hFF, 3'h7);
    check(latch_out, 8'h4D);
    check(pin_in, 8'hCD);
    step(BIOPRT_OP_READ, 8'h00, 3'h0);
    check(rd_data, 8'hCD);
  endtask
  // Main sequence
  initial
  begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    #1;
    scn_reset;
    scn_write_read;
    scn_rmw;
    report_and_stop;
  end
endmodule
`default_nettype wire
